//--- pkg/pwm_pkg.sv
// Purpose: constants shared by the match based pwm unit
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes:   match value i sits at OFF_MATCH + 4*i
`default_nettype none
package pwm_pkg;
  localparam int NMATCH = 7;
  localparam int NOUT   = 6;
  localparam int NCAP   = 2;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_COUNT  = 8'h04;
  localparam logic [7:0] OFF_MACT   = 8'h08;
  localparam logic [7:0] OFF_DEDGE  = 8'h0C;
  localparam logic [7:0] OFF_OUTEN  = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_MASK   = 8'h18;
  localparam logic [7:0] OFF_MATCH  = 8'h20;

  // control fields
  localparam int CTRL_EN    = 0;
  localparam int CTRL_CRST  = 1;
  localparam int CTRL_MODE  = 2;
  localparam int CTRL_CSEL  = 3;
  localparam int CTRL_W     = 4;
  // match action fields: three bits per match, base 3*i
  localparam int MACT_INT   = 0;
  localparam int MACT_RST   = 1;
  localparam int MACT_STOP  = 2;
  localparam int MACT_W     = 3;

  localparam logic [3:0]  CTRL_RESET  = 4'h0;
  localparam logic [20:0] MACT_RESET  = 21'h000000;
  localparam logic [5:0]  DEDGE_RESET = 6'h00;
  localparam logic [5:0]  OUTEN_RESET = 6'h00;
  localparam logic [6:0]  MASK_RESET  = 7'h00;
endpackage
`default_nettype wire

//--- hdl/pwm_unit.sv
// Purpose: match based pwm unit with seven match values and six outputs
// Assumes: all inputs synchronous to I_CORE_CLK; register port never waits
// Notes:   reading STATUS clears it; a set in the same cycle survives
//
// Decided for this implementation: strobed register access and the placing of the registers.
`default_nettype none

// Overview of operation
// [R1] running count is compared with seven match values; hits drive pins or irqs
// [R2] match zero always restarts the count, setting every output's period
// [R3] a single-edge output clears on its own match value
// [R4] every single-edge output goes high on the match-zero event
// [R5] each extra single-edge output costs one match value only
// [R6] a double-edge output rises on match n-1 and falls on match n
// [R7] each extra double-edge output costs two more match values
// [R8] rise before fall gives a positive pulse, otherwise a negative pulse
// [R9] six single, three double, or a mix within seven match values
// [R10] counter advances on core clock or rising edges of a chosen capture input
// [R11] per match: continue counting, optional interrupt
// [R12] per match: stop the counter, optional interrupt
// [R13] per match: clear the counter, optional interrupt
// [R14] count advances once per counting clock; actions happen on equality
// [R15] after a period match the count resumes from zero, period is match plus one
module pwm_unit #(
  parameter int CW = 32
) (
  input  wire logic                     I_CORE_CLK,
  input  wire logic                     I_RST_N,
  input  wire logic [7:0]               I_ADDR,
  input  wire logic [31:0]              I_WDATA,
  input  wire logic                     I_WR,
  input  wire logic                     I_RD,
  input  wire logic [pwm_pkg::NCAP-1:0] I_CAP,
  output logic      [31:0]              O_RDATA,
  output logic      [pwm_pkg::NOUT-1:0] O_PWM,
  output logic                          O_IRQ
);
  localparam int NM = pwm_pkg::NMATCH;
  localparam int NO = pwm_pkg::NOUT;

  logic [pwm_pkg::CTRL_W-1:0]       ctrl_q;
  logic [NM*pwm_pkg::MACT_W-1:0]    mact_q;
  logic [NO-1:0]                    dedge_q;
  logic [NO-1:0]                    outen_q;
  logic [NM-1:0]                    status_q;
  logic [NM-1:0]                    mask_q;
  logic [CW-1:0]                    match_q [NM];
  logic [CW-1:0]                    count_q;
  logic [NO-1:0]                    lvl_q;
  logic [pwm_pkg::NCAP-1:0]         cap_q;
  logic [31:0]                      rdata_q;
  logic                             irq_q;
  logic [NM-1:0]                    hit;
  logic [NM-1:0]                    hit_rst;
  logic [NM-1:0]                    hit_stop;
  logic [NM-1:0]                    hit_int;
  logic                             tick;
  logic                             cap_rise;

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    is_reg = (a == off);
  endfunction

  function automatic logic mact_bit(input logic [NM*pwm_pkg::MACT_W-1:0] m,
                                    input int i, input int f);
    mact_bit = m[i*pwm_pkg::MACT_W+f];
  endfunction

  // counter mode counts rising edges of the selected capture input
  assign cap_rise = I_CAP[ctrl_q[pwm_pkg::CTRL_CSEL]] & ~cap_q[ctrl_q[pwm_pkg::CTRL_CSEL]];
  assign tick = ctrl_q[pwm_pkg::CTRL_MODE] ? cap_rise : 1'b1; // [R10] [R14]

  always_comb begin
    for (int i = 0; i < NM; i++) begin
      // equality compare, qualified by a counting clock while running
      hit[i] = ctrl_q[pwm_pkg::CTRL_EN] & ~ctrl_q[pwm_pkg::CTRL_CRST] & tick
               & (count_q == match_q[i]); // [R1] [R14]
      hit_rst[i]  = hit[i] & (mact_bit(mact_q, i, pwm_pkg::MACT_RST) | (i == 0)); // [R2] [R13]
      hit_stop[i] = hit[i] & mact_bit(mact_q, i, pwm_pkg::MACT_STOP); // [R12]
      hit_int[i]  = hit[i] & mact_bit(mact_q, i, pwm_pkg::MACT_INT); // [R11]
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cap_q <= '0;
    end else begin
      cap_q <= I_CAP;
    end
  end

  // control; a stop match drops the enable unless software writes it this cycle
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_q <= pwm_pkg::CTRL_RESET;
    end else if (I_WR && is_reg(I_ADDR, pwm_pkg::OFF_CTRL)) begin
      ctrl_q <= I_WDATA[pwm_pkg::CTRL_W-1:0];
    end else if (|hit_stop) begin
      ctrl_q[pwm_pkg::CTRL_EN] <= 1'b0; // [R12]
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mact_q  <= pwm_pkg::MACT_RESET;
      dedge_q <= pwm_pkg::DEDGE_RESET;
      outen_q <= pwm_pkg::OUTEN_RESET;
      mask_q  <= pwm_pkg::MASK_RESET;
    end else if (I_WR) begin
      if (is_reg(I_ADDR, pwm_pkg::OFF_MACT)) begin
        mact_q <= I_WDATA[NM*pwm_pkg::MACT_W-1:0];
      end
      if (is_reg(I_ADDR, pwm_pkg::OFF_DEDGE)) begin
        dedge_q <= I_WDATA[NO-1:0] & {{(NO-1){1'b1}}, 1'b0};
      end
      if (is_reg(I_ADDR, pwm_pkg::OFF_OUTEN)) begin
        outen_q <= I_WDATA[NO-1:0];
      end
      if (is_reg(I_ADDR, pwm_pkg::OFF_MASK)) begin
        mask_q <= I_WDATA[NM-1:0];
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < NM; i++) begin
        match_q[i] <= '0;
      end
    end else if (I_WR) begin
      for (int i = 0; i < NM; i++) begin
        if (is_reg(I_ADDR, pwm_pkg::OFF_MATCH + 8'(4 * i))) begin
          match_q[i] <= I_WDATA[CW-1:0];
        end
      end
    end
  end

  // count: held at zero while the reset bit is set
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      count_q <= '0;
    end else if (ctrl_q[pwm_pkg::CTRL_CRST]) begin
      count_q <= '0;
    end else if (ctrl_q[pwm_pkg::CTRL_EN] && tick) begin
      if (|hit_rst) begin
        count_q <= '0; // [R2] [R13] [R15]
      end else if (!(|hit_stop)) begin
        count_q <= count_q + CW'(1); // [R11] [R14]
      end
    end
  end

  // output n uses match n; in double-edge mode it rises on match n-1 instead
  // of match zero, so a mix of both kinds shares the seven values
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lvl_q <= '0;
    end else begin
      for (int n = 0; n < NO; n++) begin
        if (!outen_q[n]) begin
          lvl_q[n] <= 1'b0;
        end else if (hit[n+1]) begin
          lvl_q[n] <= 1'b0; // [R3] [R5] [R6] [R7]
        end else if (dedge_q[n] ? hit[n] : hit[0]) begin
          lvl_q[n] <= 1'b1; // [R4] [R6] [R8] [R9]
        end
      end
    end
  end

  // read-to-clear status; a fresh event beats the clear
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      status_q <= '0;
    end else if (I_RD && is_reg(I_ADDR, pwm_pkg::OFF_STATUS)) begin
      status_q <= hit_int; // [R11] [R12] [R13]
    end else begin
      status_q <= status_q | hit_int;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_q <= '0;
    end else if (I_RD) begin
      rdata_q <= '0;
      case (I_ADDR)
        pwm_pkg::OFF_CTRL:   rdata_q <= 32'(ctrl_q);
        pwm_pkg::OFF_COUNT:  rdata_q <= 32'(count_q);
        pwm_pkg::OFF_MACT:   rdata_q <= 32'(mact_q);
        pwm_pkg::OFF_DEDGE:  rdata_q <= 32'(dedge_q);
        pwm_pkg::OFF_OUTEN:  rdata_q <= 32'(outen_q);
        pwm_pkg::OFF_STATUS: rdata_q <= 32'(status_q);
        pwm_pkg::OFF_MASK:   rdata_q <= 32'(mask_q);
        default: begin
          for (int i = 0; i < NM; i++) begin
            if (I_ADDR == pwm_pkg::OFF_MATCH + 8'(4 * i)) begin
              rdata_q <= 32'(match_q[i]);
            end
          end
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_PWM   = lvl_q;
  assign O_IRQ   = irq_q;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  // a register write may legitimately override the checked step, so it is excluded
  logic quiet;
  assign quiet = !I_WR;

  a_period_restart: assert property ( // [R2]
    hit[0] && !ctrl_q[pwm_pkg::CTRL_CRST] |=> count_q == '0)
    else $error("count did not restart on period match");

  a_resume_zero: assert property ( // [R15]
    hit[0] && quiet && !hit_stop[0] ##1 tick && ctrl_q[pwm_pkg::CTRL_EN] && quiet
      && !(|hit_rst) && !(|hit_stop) && !ctrl_q[pwm_pkg::CTRL_CRST]
    |=> count_q == CW'(1))
    else $error("count did not resume from zero");

  a_count_step: assert property ( // [R14]
    quiet && ctrl_q[pwm_pkg::CTRL_EN] && !ctrl_q[pwm_pkg::CTRL_CRST] && tick
      && !(|hit_rst) && !(|hit_stop)
    |=> count_q == $past(count_q) + CW'(1))
    else $error("count did not advance by one");

  a_counter_hold: assert property ( // [R10]
    quiet && ctrl_q[pwm_pkg::CTRL_MODE] && !cap_rise && !ctrl_q[pwm_pkg::CTRL_CRST]
    |=> $stable(count_q))
    else $error("counter mode moved without a capture edge");

  a_single_rise: assert property ( // [R4]
    outen_q[0] && hit[0] && !hit[1] && quiet |=> O_PWM[0])
    else $error("single-edge output not high at cycle start");

  a_single_fall: assert property ( // [R3]
    outen_q[0] && hit[1] && quiet |=> !O_PWM[0])
    else $error("single-edge output not low after its match");

  a_double_rise: assert property ( // [R6]
    outen_q[1] && dedge_q[1] && hit[1] && !hit[2] && quiet |=> O_PWM[1])
    else $error("double-edge output did not rise");

  a_double_fall: assert property ( // [R8]
    outen_q[1] && dedge_q[1] && hit[2] && quiet
    |=> !O_PWM[1] ##1 (!O_PWM[1] || $past(hit[1])))
    else $error("double-edge output did not fall");

  a_stop_halt: assert property ( // [R12]
    (|hit_stop) && quiet
    |=> !ctrl_q[pwm_pkg::CTRL_EN] ##1 $stable(count_q))
    else $error("counter still running after stop match");

  a_irq_flag: assert property ( // [R11]
    hit_int[3] |=> status_q[3] ##1 (O_IRQ || !$past(mask_q[3])))
    else $error("match event lost from status or irq");

  // per-match actions, counter-mode stepping and the remaining output kinds
  a_count_clear: assert property ( // [R13]
    (|hit_rst[NM-1:1]) |=> count_q == '0)
    else $error("reset match did not clear the count");

  a_stop_hold: assert property ( // [R12]
    (|hit_stop) && !(|hit_rst) |=> count_q == $past(count_q))
    else $error("count moved on a stop match");

  a_read_clear: assert property ( // [R11]
    I_RD && I_ADDR == pwm_pkg::OFF_STATUS |=> status_q == $past(hit_int))
    else $error("status read did not clear old flags");

  a_mode_step: assert property ( // [R10]
    ctrl_q[pwm_pkg::CTRL_MODE] && cap_rise && ctrl_q[pwm_pkg::CTRL_EN]
      && !ctrl_q[pwm_pkg::CTRL_CRST] && !(|hit_rst) && !(|hit_stop)
    |=> count_q == $past(count_q) + CW'(1))
    else $error("counter mode missed a capture edge");

  a_double_hold: assert property ( // [R6]
    outen_q[1] && dedge_q[1] && hit[0] && !hit[1] && !hit[2] |=> $stable(O_PWM[1]))
    else $error("double-edge output moved on the period match");

  a_single_last: assert property ( // [R5]
    outen_q[5] && !dedge_q[5] && hit[6] |=> !O_PWM[5])
    else $error("last single-edge output missed its match");

  a_neg_pulse: assert property ( // [R8]
    outen_q[3] && dedge_q[3] && hit[4] |=> !O_PWM[3])
    else $error("double-edge output four did not fall");

  a_output_off: assert property ( // [R9]
    outen_q != '1 |=> (O_PWM & ~$past(outen_q)) == '0)
    else $error("disabled output not held low");
endmodule
`default_nettype wire

//--- verification/pwm_load.sv
// Purpose: passive load on the pwm pins, counts rising edges per output
// Assumes: pins are registered levels, looked at on the core clock
// Notes:   a driver stage only sees levels, so it never drives anything back
`default_nettype none
module pwm_load (
  input wire logic                     i_clk,
  input wire logic                     i_rst_n,
  input wire logic [pwm_pkg::NOUT-1:0] i_pwm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [pwm_pkg::NOUT-1:0] last_q;
  int                       rises [pwm_pkg::NOUT];
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_q = '0;
      foreach (rises[n]) rises[n] = 0;
    end else begin
      foreach (rises[n]) if (i_pwm[n] && !last_q[n]) rises[n]++;
      last_q = i_pwm;
    end
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Purpose: self-checking bench, reference model compared on every cycle
// Assumes: random runs keep the match actions at interrupt bits only, so no action clash
// Notes:   disabled outputs are modelled as held low, so pwm is compared whole
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, irq, irqexp;
  logic [7:0]  addr = '0;
  logic [31:0] wdata = '0, rdata, rdexp;
  logic [1:0]  cap = '0, capp;
  logic [5:0]  pwm, dedge, outen, st;
  logic [6:0]  stat, mask, hit;
  logic [3:0]  ctrl;
  logic [20:0] mact;
  int          fails = 0, check_count = 0, seed = 68, cnt, m [7];

  pwm_unit uut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr_s), .I_RD(rd_s), .I_CAP(cap), .O_RDATA(rdata), .O_PWM(pwm), .O_IRQ(irq));
  pwm_load u_load (.i_clk(clk), .i_rst_n(rst_n), .i_pwm(pwm));

  always #5 clk = ~clk;

  always @(posedge clk or negedge rst_n) begin : model
    logic tick, rs, sp;
    if (!rst_n) begin
      cnt = 0;
      foreach (m[i]) m[i] = 0;
      {ctrl, mact, dedge, outen, st, stat, mask, capp, rdexp, irqexp} = '0;
    end else begin
      tick = ctrl[2] ? cap[ctrl[3]] && !capp[ctrl[3]] : 1'b1;
      capp = cap;
      irqexp = |(stat & mask);
      rdexp = '0;
      if (rd_s) case (addr)
        8'h00: rdexp = 32'(ctrl);
        8'h04: rdexp = cnt;
        8'h08: rdexp = 32'(mact);
        8'h0C: rdexp = 32'(dedge);
        8'h10: rdexp = 32'(outen);
        8'h14: rdexp = 32'(stat);
        8'h18: rdexp = 32'(mask);
        default: if (addr >= 8'h20 && addr <= 8'h38 && addr[1:0] == 2'h0)
          rdexp = m[(addr - 8'h20) >> 2];
      endcase
      if (rd_s && addr == 8'h14) stat = '0;
      rs = 0;
      sp = 0;
      for (int i = 0; i < 7; i++) begin
        hit[i] = ctrl[0] && !ctrl[1] && tick && cnt == m[i];
        rs |= hit[i] && (i == 0 || mact[3*i+1]);
        sp |= hit[i] && mact[3*i+2];
        stat[i] |= hit[i] && mact[3*i];
      end
      for (int n = 1; n < 7; n++)
        if (!outen[n-1] || hit[n]) st[n-1] = 0;
        else if (dedge[n-1] ? hit[n-1] : hit[0]) st[n-1] = 1;
      if (ctrl[1]) cnt = 0;
      else if (ctrl[0] && tick) begin
        if (rs) cnt = 0;
        else if (!sp) cnt++;
        if (sp) ctrl[0] = 0;
      end
      if (wr_s) case (addr)
        8'h00: ctrl = wdata[3:0];
        8'h08: mact = wdata[20:0];
        8'h0C: dedge = wdata[5:0] & 6'h3E;
        8'h10: outen = wdata[5:0];
        8'h18: mask = wdata[6:0];
        default: if (addr >= 8'h20 && addr <= 8'h38 && addr[1:0] == 2'h0)
          m[(addr - 8'h20) >> 2] = wdata;
      endcase
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  always @(negedge clk) if (rst_n) begin
    chk("pwm", 32'(st), 32'(pwm));
    chk("irq", 32'(irqexp), 32'(irq));
    chk("rdata", rdexp, rdata);
  end

  task automatic run(input int n);
    repeat (n) begin
      @(posedge clk);
      cap <= 2'($random(seed));
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
  endtask

  task summarize;
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h1C);
    rd(8'h00);
    // six single-edge outputs on matches 1 to 6 holding 0 to 5; period of five counts, so match 6 is never reached
    wr(8'h20, 4);
    for (int i = 1; i < 7; i++) wr(8'h20 + 8'(4 * i), i - 1);
    wr(8'h10, 6'h3F);
    wr(8'h18, 7'h7F);
    wr(8'h08, 21'h49249);
    wr(8'h00, 1);
    run(30);
    rd(8'h14);
    rd(8'h14);
    rd(8'h04);
    chk("rises", 1, u_load.rises[1] > 0);
    // out2 positive pulse, out4 negative pulse, out6 double too
    wr(8'h0C, 6'h2A);
    wr(8'h20, 9);
    wr(8'h24, 2);
    wr(8'h28, 6);
    wr(8'h2C, 7);
    wr(8'h30, 3);
    run(40);
    wr(8'h08, 21'h49259);
    run(20);
    wr(8'h08, 21'h49A49);
    run(20);
    rd(8'h00);
    rd(8'h04);
    wr(8'h08, 21'h49249);
    wr(8'h00, 4'hD);
    run(60);
    wr(8'h00, 4'h5);
    run(60);
    for (int k = 0; k < 5; k++) begin
      // hold the count at zero so a shorter period cannot strand it above match zero
      wr(8'h00, 2);
      for (int i = 0; i < 7; i++)
        wr(8'h20 + 8'(4 * i), (i == 0 ? 6 : 0) + $unsigned($random(seed)) % 12);
      wr(8'h0C, $random(seed));
      wr(8'h18, $random(seed));
      wr(8'h00, 1);
      run(40);
      rd(8'h14);
    end
    for (int a = 0; a < 'h40; a += 4) rd(8'(a));
    wr(8'h00, 3);
    run(3);
    rd(8'h04);
    wr(8'h10, 0);
    run(2);
    chk("off", 0, 32'(pwm));
    summarize;
  end
endmodule
`default_nettype wire
